// [hw/tmqc_defines.svh]
// offsets, field positions, reset values and timing counts of the queue/mode configuration block
// Functional notes
// - bit 15 selects enhanced bus controller mode
// - bit 14 shortens host wait during messages
// - bit 14 low: host waits whole sequence, at most 900 cycles
// - bit 13 steps stack pointer by four
// - bit 12 enables global ring buffer
// - bits 11-9 select ring size, zero disables
// - bit 8 drops queue entries of invalid messages
// - bit 7 drops queue entries of valid messages
// - bit 6 enables interrupt status queue writes
`ifndef TMQC_DEFINES_SVH
`define TMQC_DEFINES_SVH

// ********************
// register map
// ********************
`define TMQC_CFG_OFFSET 16'h0018
`define TMQC_CFG_RESET 16'h0000
`define TMQC_CFG_MASK 16'hFFC0

// ********************
// field positions
// ********************
`define TMQC_ENH_BIT 15
`define TMQC_WAIT_BIT 14
`define TMQC_STK_BIT 13
`define TMQC_RING_EN_BIT 12
`define TMQC_RING_SZ_HI 11
`define TMQC_RING_SZ_LO 9
`define TMQC_SKIP_INV_BIT 8
`define TMQC_SKIP_VAL_BIT 7
`define TMQC_QEN_BIT 6

// ********************
// stack and timing
// ********************
`define TMQC_STACK_STEP 16'h0004
`define TMQC_RING_MIN_WORDS 14'h0080
`define TMQC_RING_MAX_WORDS 14'h2000
`define TMQC_CLK_NS 4
`define TMQC_FULL_WAIT_NS 3600
`define TMQC_REDUCED_WAIT_NS 500
`define TMQC_FULL_WAIT_CYC (`TMQC_FULL_WAIT_NS / `TMQC_CLK_NS)
`define TMQC_REDUCED_WAIT_CYC (`TMQC_REDUCED_WAIT_NS / `TMQC_CLK_NS)

`endif

// [hw/tmqc_pkg.sv]
// types shared by the queue/mode configuration block
package tmqc_pkg;
  typedef enum logic {TMQC_IDLE, TMQC_HOLD} tmqc_hold_state_type;
  typedef logic [9:0] tmqc_count_type;
endpackage

// [hw/tmqc_hold.sv]
// host access hold-off timer while a bus message is in progress
`timescale 1ns/10ps
`include "tmqc_defines.svh"
module tmqc_hold (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic reduced_host_wait,
  input wire logic msg_busy,
  input wire logic host_req,
  // status
  output logic host_wait
);
  tmqc_pkg::tmqc_hold_state_type state_r;
  tmqc_pkg::tmqc_count_type cnt_r;

  // hold starts when the host asks while a message runs; ends on count or sequence end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= tmqc_pkg::TMQC_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        tmqc_pkg::TMQC_IDLE: begin
          if (host_req && msg_busy) begin
            state_r <= tmqc_pkg::TMQC_HOLD;
            cnt_r <= reduced_host_wait ? 10'(`TMQC_REDUCED_WAIT_CYC) : 10'(`TMQC_FULL_WAIT_CYC);
          end
        end
        tmqc_pkg::TMQC_HOLD: begin
          cnt_r <= cnt_r - 10'd1;
          // full mode ends with the sequence; count is only a ceiling
          if (!msg_busy || cnt_r == 10'd1) begin
            state_r <= tmqc_pkg::TMQC_IDLE;
          end
        end
        default: state_r <= tmqc_pkg::TMQC_IDLE;
      endcase
    end
  end

  assign host_wait = (state_r == tmqc_pkg::TMQC_HOLD);

  // reduced wait bounded by its short count
  a_reduced_wait_bound: assert property (@(posedge clock) disable iff (!rstn)
    (host_req && msg_busy && !host_wait && reduced_host_wait) |=> ##[0:125] !host_wait)
    else $error("reduced host wait too long");
  // full wait never beyond its ceiling
  a_full_wait_bound: assert property (@(posedge clock) disable iff (!rstn)
    (host_req && msg_busy && !host_wait && !reduced_host_wait) |=> ##[0:900] !host_wait)
    else $error("full host wait too long");
  // full mode keeps holding through the first eight busy cycles of the message sequence
  a_full_wait_holds: assert property (@(posedge clock) disable iff (!rstn)
    (host_req && msg_busy && !host_wait && !reduced_host_wait) ##1 msg_busy [*8] |-> host_wait)
    else $error("full host wait released early");
endmodule

// [hw/tmqc_top.sv]
// configuration register for bus controller mode, stack advance, ring buffer and status queue
`timescale 1ns/10ps
`include "tmqc_defines.svh"
module tmqc_top (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // host register port
  input wire logic [15:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  // host bus arbitration
  input wire logic host_req,
  input wire logic msg_busy,
  output logic host_wait,
  // message events
  input wire logic message_end,
  input wire logic msg_irq,
  input wire logic msg_valid,
  // mode and buffer controls
  output logic enhanced_controller_select,
  output logic global_ring_enable,
  output logic [13:0] ring_words,
  output logic [15:0] stack_ptr,
  // interrupt status queue
  output logic irq_raise,
  output logic queue_write
);
  // ********************
  // register storage
  // ********************
  logic [15:0] cfg_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic [15:0] stack_r;
  logic [13:0] ring_r;
  logic irq_r;
  logic qwr_r;
  logic hold_r;
  logic hold_nxt;
  logic wr_hit;
  logic skip_entry;

  // ring size: code zero turns buffering off
  function automatic logic [13:0] ring_decode(input logic [2:0] code);
    ring_decode = (code == 3'h0) ? 14'h0000 : (14'h0040 << code);
  endfunction

  assign wr_hit = host_wr && (host_addr == `TMQC_CFG_OFFSET);

  // config write; only bits 15-6 exist here, the rest read zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_r <= `TMQC_CFG_RESET;
    end else if (wr_hit) begin
      cfg_r <= host_wdata & `TMQC_CFG_MASK;
    end
  end

  // registered read port, unmapped addresses return zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_rd;
      rdata_r <= (host_rd && host_addr == `TMQC_CFG_OFFSET) ? cfg_r : 16'h0000;
    end
  end

  // ********************
  // stack pointer and ring
  // ********************
  // stack moves by four at each message end when enabled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stack_r <= 16'h0000;
    end else if (message_end && cfg_r[`TMQC_STK_BIT]) begin
      stack_r <= stack_r + `TMQC_STACK_STEP;
    end
  end

  // ring size only counts while the ring is enabled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ring_r <= 14'h0000;
    end else begin
      ring_r <= cfg_r[`TMQC_RING_EN_BIT] ? ring_decode(cfg_r[`TMQC_RING_SZ_HI:`TMQC_RING_SZ_LO]) : 14'h0000;
    end
  end

  // ********************
  // interrupt status queue
  // ********************
  // interrupts always pass; skip bits only suppress the queue entry
  assign skip_entry = msg_valid ? cfg_r[`TMQC_SKIP_VAL_BIT] : cfg_r[`TMQC_SKIP_INV_BIT];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_r <= 1'b0;
      qwr_r <= 1'b0;
    end else begin
      irq_r <= msg_irq;
      qwr_r <= msg_irq && cfg_r[`TMQC_QEN_BIT] && !skip_entry;
    end
  end

  // ********************
  // host hold-off
  // ********************
  tmqc_hold u_hold (
    .clock(clock),
    .rstn(rstn),
    .reduced_host_wait(cfg_r[`TMQC_WAIT_BIT]),
    .msg_busy(msg_busy),
    .host_req(host_req),
    .host_wait(hold_nxt)
  );

  // retimed so the pin comes from a flop; adds one cycle of latency
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign host_rdata = rdata_r;
  assign host_rvalid = rvalid_r;
  assign host_wait = hold_r;
  assign enhanced_controller_select = cfg_r[`TMQC_ENH_BIT];
  assign global_ring_enable = cfg_r[`TMQC_RING_EN_BIT];
  assign ring_words = ring_r;
  assign stack_ptr = stack_r;
  assign irq_raise = irq_r;
  assign queue_write = qwr_r;

  // ********************
  // register checks
  // ********************
  // mode bit follows the last write
  a_enh_mode_follows: assert property (@(posedge clock) disable iff (!rstn)
    wr_hit |=> enhanced_controller_select == $past(host_wdata[`TMQC_ENH_BIT]))
    else $error("enhanced mode bit not taken");
  // ring enable pin follows the last write
  a_ring_enable_out: assert property (@(posedge clock) disable iff (!rstn)
    wr_hit |=> global_ring_enable == $past(host_wdata[`TMQC_RING_EN_BIT]))
    else $error("ring enable bit not taken");
  // a read right after a write returns the written upper bits
  a_readback_match: assert property (@(posedge clock) disable iff (!rstn)
    (wr_hit ##1 (host_rd && host_addr == `TMQC_CFG_OFFSET && !host_wr)) |=>
      host_rdata == ($past(host_wdata, 2) & `TMQC_CFG_MASK))
    else $error("readback differs from written value");
  // register only changes on a write to its own offset
  a_cfg_held: assert property (@(posedge clock) disable iff (!rstn)
    !wr_hit |=> $stable(cfg_r))
    else $error("register changed without a write");
  // every read strobe gets exactly one valid pulse, one cycle late
  a_rvalid_pulse: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> host_rvalid == $past(host_rd))
    else $error("read valid does not follow read strobe");
  // reads of other offsets return zero
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
    (host_rd && host_addr != `TMQC_CFG_OFFSET) |=> host_rdata == 16'h0000)
    else $error("unmapped read returned data");
  // the low six bits live elsewhere and read zero here
  a_low_bits_zero: assert property (@(posedge clock) disable iff (!rstn)
    host_rvalid |-> (host_rdata & ~`TMQC_CFG_MASK) == 16'h0000)
    else $error("low bits read nonzero");

  // ********************
  // stack and ring checks
  // ********************
  // enabled message end steps the stack by four
  a_stack_step_four: assert property (@(posedge clock) disable iff (!rstn)
    (message_end && cfg_r[`TMQC_STK_BIT]) |=> stack_ptr == $past(stack_ptr) + `TMQC_STACK_STEP)
    else $error("stack pointer did not advance by four");
  // otherwise the stack stands
  a_stack_held: assert property (@(posedge clock) disable iff (!rstn)
    !(message_end && cfg_r[`TMQC_STK_BIT]) |=> $stable(stack_ptr))
    else $error("stack pointer moved without message end");
  // disabled ring or size code zero reports no ring
  a_ring_off_zero: assert property (@(posedge clock) disable iff (!rstn)
    (!cfg_r[`TMQC_RING_EN_BIT] || cfg_r[`TMQC_RING_SZ_HI:`TMQC_RING_SZ_LO] == 3'h0) |=> ring_words == 14'h0000)
    else $error("ring size nonzero while disabled");
  // smallest size code
  a_ring_smallest: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_r[`TMQC_RING_EN_BIT] && cfg_r[`TMQC_RING_SZ_HI:`TMQC_RING_SZ_LO] == 3'h1) |=> ring_words == `TMQC_RING_MIN_WORDS)
    else $error("ring size code one not 128 words");
  // largest size code
  a_ring_largest: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_r[`TMQC_RING_EN_BIT] && cfg_r[`TMQC_RING_SZ_HI:`TMQC_RING_SZ_LO] == 3'h7) |=> ring_words == `TMQC_RING_MAX_WORDS)
    else $error("ring size code seven not 8192 words");

  // ********************
  // queue checks
  // ********************
  // interrupts pass whatever the queue bits say
  a_irq_always: assert property (@(posedge clock) disable iff (!rstn)
    msg_irq |=> irq_raise)
    else $error("interrupt lost");
  // invalid message with its skip bit set leaves no entry
  a_skip_invalid: assert property (@(posedge clock) disable iff (!rstn)
    (msg_irq && !msg_valid && cfg_r[`TMQC_SKIP_INV_BIT]) |=> irq_raise && !queue_write)
    else $error("invalid message queued or interrupt lost");
  // valid message with its skip bit set leaves no entry
  a_skip_valid: assert property (@(posedge clock) disable iff (!rstn)
    (msg_irq && msg_valid && cfg_r[`TMQC_SKIP_VAL_BIT]) |=> irq_raise && !queue_write)
    else $error("valid message queued or interrupt lost");
  // queue switched off writes nothing
  a_queue_off: assert property (@(posedge clock) disable iff (!rstn)
    (msg_irq && !cfg_r[`TMQC_QEN_BIT]) |=> !queue_write)
    else $error("queue written while disabled");
  // queue write against enable and the skip bit of the message kind
  a_queue_gate: assert property (@(posedge clock) disable iff (!rstn)
    msg_irq |=> queue_write == ($past(cfg_r[`TMQC_QEN_BIT]) &&
      !($past(msg_valid) ? $past(cfg_r[`TMQC_SKIP_VAL_BIT]) : $past(cfg_r[`TMQC_SKIP_INV_BIT]))))
    else $error("queue write does not follow enable");
  // no event, no pulse
  a_events_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !msg_irq |=> !irq_raise && !queue_write)
    else $error("queue or interrupt pulse without event");

  // ********************
  // hold-off checks
  // ********************
  // pin is the hold state one cycle late
  a_wait_retimed: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> host_wait == $past(hold_nxt))
    else $error("host wait pin not retimed hold state");
endmodule

// [bench/tmqc_host_model.sv]
// host processor model driving the register port and bus requests
`timescale 1ns/10ps
module tmqc_host_model (
  // clock
  input wire logic clock,
  // host register port
  output logic [15:0] host_addr,
  output logic [15:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input wire logic [15:0] host_rdata,
  // bus request
  output logic host_req
);
  // idle bus; wdata idles inverted so stale data is never mistaken for fresh
  initial begin
    host_addr = 16'h0000;
    host_wdata = 16'hA5A5;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_req = 1'b0;
  end
  // one write strobe; a clock passes first so back to back strobes stay apart
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  // one read strobe; data stands only in the cycle after the taking edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clock);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    d = host_rdata;
    host_rd = 1'b0;
  endtask
endmodule

// [bench/terminal_mode_queue_config_bench.sv]
// self-checking bench for the queue/mode configuration register
`timescale 1ns/10ps
module terminal_mode_queue_config_bench;
  logic clock, rstn, host_wr, host_rd, host_req, host_rvalid, host_wait;
  logic msg_busy, message_end, msg_irq, msg_valid, irq_raise, queue_write, enh, ring_en;
  logic [15:0] host_addr, host_wdata, host_rdata, stack_ptr, d;
  logic [13:0] ring_words;
  int err_count = 0, cmp_count = 0, cyc = 0;
  tmqc_host_model i_host (.clock(clock), .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_req(host_req));
  tmqc_top i_dut (.clock(clock), .rstn(rstn), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_req(host_req), .msg_busy(msg_busy), .host_wait(host_wait), .message_end(message_end),
    .msg_irq(msg_irq), .msg_valid(msg_valid), .enhanced_controller_select(enh),
    .global_ring_enable(ring_en), .ring_words(ring_words), .stack_ptr(stack_ptr),
    .irq_raise(irq_raise), .queue_write(queue_write));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ceiling far above the longest hold-off run
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_regs();
    i_host.rd(16'h0018, d); chk("reset", 16'h0000, d);
    i_host.wr(16'h0018, 16'hFFFF); chk("enh", 16'h0001, {15'h0000, enh});
    chk("ring_en", 16'h0001, {15'h0000, ring_en});
    i_host.rd(16'h0018, d); chk("readback", 16'hFFC0, d);
    chk("rvalid", 16'h0001, {15'h0000, host_rvalid});
    i_host.wr(16'h0010, 16'h0000); i_host.rd(16'h0010, d); chk("unmapped", 16'h0000, d);
    i_host.rd(16'h0018, d); chk("kept", 16'hFFC0, d);
  endtask
  // every size code, enable held on
  task automatic t_ring();
    for (int c = 0; c < 8; c++) begin
      i_host.wr(16'h0018, 16'h1000 | 16'(c << 9));
      @(negedge clock);
      chk("ring_words", c == 0 ? 16'h0000 : 16'(64 << c), {2'b00, ring_words});
    end
    // size code set but ring disabled
    i_host.wr(16'h0018, 16'h0E00);
    @(negedge clock);
    chk("ring_off", 16'h0000, {2'b00, ring_words});
  endtask
  task automatic t_stack();
    i_host.wr(16'h0018, 16'h2000);
    repeat (2) begin
      message_end = 1'b1; @(negedge clock); message_end = 1'b0; @(negedge clock);
    end
    chk("stack_ptr", 16'h0008, stack_ptr);
    i_host.wr(16'h0018, 16'h0000);
    message_end = 1'b1; @(negedge clock); message_end = 1'b0; @(negedge clock);
    chk("stack_kept", 16'h0008, stack_ptr);
  endtask
  // queue enable and both skip bits against both message kinds
  task automatic t_queue();
    for (int k = 0; k < 16; k++) begin
      i_host.wr(16'h0018, 16'((k & 7) << 6));
      msg_irq = 1'b1; msg_valid = k[3]; @(negedge clock); msg_irq = 1'b0;
      chk("irq_raise", 16'h0001, {15'h0000, irq_raise});
      chk("queue_write", 16'(k[0] && !(k[3] ? k[1] : k[2])), {15'h0000, queue_write});
      @(negedge clock);
    end
  endtask
  // request taken once, bus kept busy; hold ends by count or by busy
  task automatic t_hold(input logic fast);
    i_host.wr(16'h0018, {1'b0, fast, 14'h0000});
    i_host.host_req = 1'b1; @(negedge clock); i_host.host_req = 1'b0;
    repeat (2) @(negedge clock);
    chk("wait_idle", 16'h0000, {15'h0000, host_wait});
    i_host.host_req = 1'b1; msg_busy = 1'b1; @(negedge clock); i_host.host_req = 1'b0;
    @(negedge clock); chk("wait_on", 16'h0001, {15'h0000, host_wait});
    repeat (110) @(negedge clock);
    chk("wait_mid", 16'h0001, {15'h0000, host_wait});
    repeat (30) @(negedge clock);
    chk("wait_cut", {15'h0000, ~fast}, {15'h0000, host_wait});
    msg_busy = 1'b0; repeat (3) @(negedge clock);
    chk("wait_off", 16'h0000, {15'h0000, host_wait});
  endtask
  // reset in mid-run clears register, pins and stack
  task automatic t_reset();
    i_host.wr(16'h0018, 16'hFFFF);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    chk("enh_rst", 16'h0000, {15'h0000, enh});
    chk("ring_en_rst", 16'h0000, {15'h0000, ring_en});
    chk("stack_rst2", 16'h0000, stack_ptr);
    i_host.rd(16'h0018, d); chk("cfg_rst", 16'h0000, d);
  endtask
  initial begin
    rstn = 1'b0; msg_busy = 1'b0; message_end = 1'b0; msg_irq = 1'b0; msg_valid = 1'b0;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    chk("stack_rst", 16'h0000, stack_ptr);
    t_regs();
    t_ring();
    t_stack();
    t_queue();
    t_hold(1'b1);
    t_hold(1'b0);
    t_reset();
    final_report();
  end
endmodule
